// [hdl/iesw_ctrl.sv]
`timescale 1ns/1ps
module iesw_ctrl #(
  parameter int NSRC = iesw_pkg::NUM_SRC
) (
  // clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            rst_b_i,
  // external pins and peripheral requests
  input  wire logic            port0_bit0_i,
  input  wire logic            port0_bit1_i,
  input  wire logic [NSRC-3:0] periph_irq_i,
  // core side
  iesw_if.dev                  cpu
);
  typedef enum logic [1:0] {
    IESW_RUN   = 2'b00,
    IESW_ACPT  = 2'b01,
    IESW_SLEEP = 2'b10,
    IESW_WAKE  = 2'b11
  } iesw_state_t;

  iesw_state_t state_ff;
  iesw_state_t nxt_state;
  logic [7:0]  edge_select_ff;
  logic [7:0]  sleep_control_ff;
  logic [7:0]  pin_function_select_ff;
  logic [7:0]  irq_enable_high_ff;
  logic [7:0]  irq_enable_low_ff;
  logic [7:0]  bit_prescale_ff;
  logic [1:0]  mc_cnt_ff;
  logic        mc_tick;
  logic        edge_a;
  logic        edge_b;
  logic        ext_irq_a_request_flag_ff;
  logic        ext_irq_b_request_flag_ff;
  logic        ext_a_poll_ff;
  logic        ext_b_poll_ff;
  logic        brk_pend_ff;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] enab;
  logic [NSRC-1:0] live;
  logic [2:0]  win_idx;
  logic        win_any;
  logic [2:0]  sel_ff;
  logic        sel_brk_ff;
  logic [3:0]  acc_cnt_ff;
  logic [7:0]  bit_cnt_ff;
  logic [7:0]  pre_cnt_ff;
  logic        vec_req_ff;
  logic [7:0]  vec_addr_ff;
  logic        vec_brk_ff;
  logic        push_ff;
  logic        clr_iflag_ff;
  logic        resume_ff;
  logic [7:0]  rdata_ff;
  logic        clr_sel;
  logic [3:0]  age_a_ff;
  logic [3:0]  age_b_ff;
  logic        age_a_done;
  logic        age_b_done;

  // machine cycle enable
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mc_cnt_ff <= 2'h0;
    end else begin
      mc_cnt_ff <= mc_cnt_ff + 2'h1;
    end
  end
  assign mc_tick = (mc_cnt_ff == 2'(iesw_pkg::MACHINE_DIV - 1));

  iesw_edge_det u_edge_a (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .line_i     (port0_bit0_i),
    .enable_i   (pin_function_select_ff[0]),
    .mode_i     (edge_select_ff[iesw_pkg::EDGE_A_LSB +: 2]),
    .edge_o     (edge_a)
  );
  iesw_edge_det u_edge_b (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .line_i     (port0_bit1_i),
    .enable_i   (pin_function_select_ff[1]),
    .mode_i     (edge_select_ff[iesw_pkg::EDGE_B_LSB +: 2]),
    .edge_o     (edge_b)
  );

  // register writes; sleep bit also cleared by hardware on release
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      edge_select_ff         <= iesw_pkg::EDGE_SELECT_RST;
      sleep_control_ff       <= iesw_pkg::SLEEP_CONTROL_RST;
      pin_function_select_ff <= iesw_pkg::PIN_FUNC_RST;
      irq_enable_high_ff     <= iesw_pkg::IRQ_EN_RST;
      irq_enable_low_ff      <= iesw_pkg::IRQ_EN_RST;
      bit_prescale_ff        <= iesw_pkg::BIT_PRESCALE_RST;
    end else begin
      // any write to another register must not hold off the release clear
      if (state_ff == IESW_WAKE && nxt_state == IESW_RUN) begin
        sleep_control_ff[iesw_pkg::SLEEP_REQ_BIT] <= 1'b0;
      end
      if (cpu.reg_wr) begin
        unique case (cpu.reg_addr)
          iesw_pkg::EDGE_SELECT_ADDR:   edge_select_ff <= cpu.reg_wdata;
          iesw_pkg::SLEEP_CONTROL_ADDR: sleep_control_ff <= cpu.reg_wdata;
          iesw_pkg::PIN_FUNC_ADDR:      pin_function_select_ff <= cpu.reg_wdata;
          iesw_pkg::IRQ_EN_HIGH_ADDR:   irq_enable_high_ff <= cpu.reg_wdata;
          iesw_pkg::IRQ_EN_LOW_ADDR:    irq_enable_low_ff <= cpu.reg_wdata;
          iesw_pkg::BIT_PRESCALE_ADDR:  bit_prescale_ff <= cpu.reg_wdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 8'h00;
    end else if (cpu.reg_rd) begin
      unique case (cpu.reg_addr)
        iesw_pkg::EDGE_SELECT_ADDR:   rdata_ff <= edge_select_ff;
        iesw_pkg::SLEEP_CONTROL_ADDR: rdata_ff <= sleep_control_ff;
        iesw_pkg::PIN_FUNC_ADDR:      rdata_ff <= pin_function_select_ff;
        iesw_pkg::IRQ_EN_HIGH_ADDR:   rdata_ff <= irq_enable_high_ff;
        iesw_pkg::IRQ_EN_LOW_ADDR:    rdata_ff <= irq_enable_low_ff;
        iesw_pkg::BIT_PRESCALE_ADDR:  rdata_ff <= bit_prescale_ff;
        default:                      rdata_ff <= 8'h00;
      endcase
    end
  end
  assign cpu.reg_rdata = rdata_ff;

  // request flags: edge set wins over acceptance clear
  assign clr_sel = (state_ff == IESW_ACPT) && (acc_cnt_ff == 4'h0);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_irq_a_request_flag_ff <= 1'b0;
      ext_irq_b_request_flag_ff <= 1'b0;
      ext_a_poll_ff             <= 1'b0;
      ext_b_poll_ff             <= 1'b0;
      brk_pend_ff               <= 1'b0;
    end else begin
      if (edge_a) begin
        ext_irq_a_request_flag_ff <= 1'b1;
      end else if (clr_sel && !sel_brk_ff && sel_ff == 3'h0) begin
        ext_irq_a_request_flag_ff <= 1'b0;
      end
      if (edge_b) begin
        ext_irq_b_request_flag_ff <= 1'b1;
      end else if (clr_sel && !sel_brk_ff && sel_ff == 3'h1) begin
        ext_irq_b_request_flag_ff <= 1'b0;
      end
      // polled copy takes the flag at the next machine cycle tick; acceptance clears it at once
      if (mc_tick) begin
        ext_a_poll_ff <= ext_irq_a_request_flag_ff & ~clr_sel;
        ext_b_poll_ff <= ext_irq_b_request_flag_ff & ~clr_sel;
      end else if (clr_sel) begin
        ext_a_poll_ff <= 1'b0;
        ext_b_poll_ff <= 1'b0;
      end
      if (cpu.brk_exec) begin
        brk_pend_ff <= 1'b1;
      end else if (clr_sel && sel_brk_ff) begin
        brk_pend_ff <= 1'b0;
      end
    end
  end

  // external requests age a full response time before they count, so no call
  // comes sooner than the minimum, whatever the instruction length
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      age_a_ff <= 4'h0;
      age_b_ff <= 4'h0;
    end else begin
      if (!ext_irq_a_request_flag_ff) begin
        age_a_ff <= 4'h0;
      end else if (mc_tick && !age_a_done) begin
        age_a_ff <= age_a_ff + 4'h1;
      end
      if (!ext_irq_b_request_flag_ff) begin
        age_b_ff <= 4'h0;
      end else if (mc_tick && !age_b_done) begin
        age_b_ff <= age_b_ff + 4'h1;
      end
    end
  end
  assign age_a_done = (age_a_ff == 4'(iesw_pkg::MIN_RESP_CYCLES));
  assign age_b_done = (age_b_ff == 4'(iesw_pkg::MIN_RESP_CYCLES));

  assign pend = {periph_irq_i, ext_b_poll_ff & age_b_done, ext_a_poll_ff & age_a_done};
  assign enab = {irq_enable_low_ff[NSRC-3:0], irq_enable_high_ff[7:6]};
  assign live = pend & enab;

  // lowest index wins, fixed polling order
  always_comb begin
    win_idx = 3'h0;
    win_any = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        win_idx = 3'(i);
        win_any = 1'b1;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IESW_RUN: begin
        if ((win_any || brk_pend_ff) && cpu.psw_iflag && cpu.instr_done && mc_tick) begin
          nxt_state = IESW_ACPT;
        end else if (sleep_control_ff[iesw_pkg::SLEEP_REQ_BIT]) begin
          nxt_state = IESW_SLEEP;
        end
      end
      IESW_ACPT: begin
        if (acc_cnt_ff == 4'(iesw_pkg::ACCEPT_CLKS - 1)) begin
          nxt_state = IESW_RUN;
        end
      end
      IESW_SLEEP: begin
        if (win_any) begin
          nxt_state = IESW_WAKE;
        end
      end
      IESW_WAKE: begin
        if (bit_cnt_ff == iesw_pkg::BIT_TOP && pre_cnt_ff == bit_prescale_ff) begin
          nxt_state = IESW_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= IESW_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // acceptance sequencing
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_cnt_ff   <= 4'h0;
      sel_ff       <= 3'h0;
      sel_brk_ff   <= 1'b0;
      vec_req_ff   <= 1'b0;
      vec_addr_ff  <= 8'h00;
      vec_brk_ff   <= 1'b0;
      push_ff      <= 1'b0;
      clr_iflag_ff <= 1'b0;
    end else begin
      push_ff      <= 1'b0;
      clr_iflag_ff <= 1'b0;
      if (state_ff == IESW_RUN && nxt_state == IESW_ACPT) begin
        acc_cnt_ff   <= 4'h0;
        sel_ff       <= win_idx;
        sel_brk_ff   <= ~win_any;
        clr_iflag_ff <= 1'b1;
      end else if (state_ff == IESW_ACPT) begin
        acc_cnt_ff <= acc_cnt_ff + 4'h1;
        if (acc_cnt_ff == 4'h1) begin
          push_ff <= 1'b1;
        end
        if (nxt_state == IESW_RUN) begin
          vec_req_ff  <= 1'b1;
          vec_brk_ff  <= sel_brk_ff;
          vec_addr_ff <= sel_brk_ff ? iesw_pkg::VEC_BRK
                                    : iesw_pkg::VEC_BASE + {4'h0, sel_ff, 1'b0};
        end
      end
      if (vec_req_ff && cpu.vec_ack) begin
        vec_req_ff <= 1'b0;
      end
    end
  end
  assign cpu.vec_req     = vec_req_ff;
  assign cpu.vec_addr    = vec_addr_ff;
  assign cpu.vec_brk     = vec_brk_ff;
  assign cpu.push_pc_psw = push_ff;
  assign cpu.clr_iflag   = clr_iflag_ff;

  // wake timer: interval count 00 to ff paced by prescaler
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_ff <= iesw_pkg::BIT_START;
      pre_cnt_ff <= 8'h00;
      resume_ff  <= 1'b0;
    end else begin
      resume_ff <= 1'b0;
      if (state_ff != IESW_WAKE) begin
        bit_cnt_ff <= iesw_pkg::BIT_START;
        pre_cnt_ff <= 8'h00;
      end else if (pre_cnt_ff == bit_prescale_ff) begin
        pre_cnt_ff <= 8'h00;
        bit_cnt_ff <= bit_cnt_ff + 8'h01;
        // without master enable the core simply continues
        resume_ff  <= (nxt_state == IESW_RUN) && !cpu.psw_iflag;
      end else begin
        pre_cnt_ff <= pre_cnt_ff + 8'h01;
      end
    end
  end
  assign cpu.resume   = resume_ff;
  assign cpu.cpu_halt = (state_ff == IESW_SLEEP) || (state_ff == IESW_WAKE);
endmodule : iesw_ctrl

// [pkg/iesw_pkg.sv]
// shared constants for the interrupt, edge and sleep controller
package iesw_pkg;
  // register offsets
  localparam logic [7:0] EDGE_SELECT_ADDR   = 8'he6;
  localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'he7;
  localparam logic [7:0] PIN_FUNC_ADDR      = 8'he8;
  localparam logic [7:0] IRQ_EN_HIGH_ADDR   = 8'he9;
  localparam logic [7:0] IRQ_EN_LOW_ADDR    = 8'hea;
  localparam logic [7:0] BIT_PRESCALE_ADDR  = 8'heb;
  // reset values
  localparam logic [7:0] EDGE_SELECT_RST    = 8'h00;
  localparam logic [7:0] SLEEP_CONTROL_RST  = 8'h00;
  localparam logic [7:0] PIN_FUNC_RST       = 8'h00;
  localparam logic [7:0] IRQ_EN_RST         = 8'h00;
  localparam logic [7:0] BIT_PRESCALE_RST   = 8'h00;
  // field positions
  localparam int SLEEP_REQ_BIT  = 0;
  localparam int EDGE_A_LSB     = 0;
  localparam int EDGE_B_LSB     = 2;
  localparam int PSW_BRK_BIT    = 4;
  localparam int PSW_IFLAG_BIT  = 2;
  // edge modes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // sources and vectors
  localparam int NUM_SRC = 8;
  localparam logic [7:0] VEC_BRK  = 8'hde;
  localparam logic [7:0] VEC_BASE = 8'he0;
  // timing
  localparam int MACHINE_DIV     = 4;
  localparam int ACCEPT_CLKS     = 8;
  localparam int MIN_RESP_CYCLES = 12;
  localparam logic [7:0] BIT_TOP = 8'hff;
  localparam logic [7:0] BIT_START = 8'h00;
endpackage : iesw_pkg

// [pkg/iesw_if.sv]
// link between the interrupt controller and the cpu core
`timescale 1ns/1ps
interface iesw_if;
  // register access from the core
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  // core status and instruction events
  logic       psw_iflag;
  logic       instr_done;
  logic       brk_exec;
  logic       iflag_set;
  // vectoring towards the core
  logic       vec_req;
  logic [7:0] vec_addr;
  logic       vec_brk;
  logic       vec_ack;
  logic       push_pc_psw;
  logic       clr_iflag;
  logic       cpu_halt;
  logic       resume;
  modport dev (
    input  reg_wr, reg_rd, reg_addr, reg_wdata, psw_iflag, instr_done, brk_exec,
    input  iflag_set, vec_ack,
    output reg_rdata, vec_req, vec_addr, vec_brk, push_pc_psw, clr_iflag, cpu_halt,
    output resume
  );
  modport core (
    output reg_wr, reg_rd, reg_addr, reg_wdata, psw_iflag, instr_done, brk_exec,
    output iflag_set, vec_ack,
    input  reg_rdata, vec_req, vec_addr, vec_brk, push_pc_psw, clr_iflag, cpu_halt,
    input  resume
  );
endinterface : iesw_if

// [hdl/iesw_edge_det.sv]
// synchronised edge detector with selectable mode for one external line
`timescale 1ns/1ps
module iesw_edge_det (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // line and control
  input  wire logic       line_i,
  input  wire logic       enable_i,
  input  wire logic [1:0] mode_i,
  // event
  output logic            edge_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= line_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_comb begin
    edge_o = 1'b0;
    if (enable_i) begin
      unique case (mode_i)
        iesw_pkg::EDGE_RISE: edge_o = ~s3_ff & s2_ff;
        iesw_pkg::EDGE_FALL: edge_o = s3_ff & ~s2_ff;
        // codes 10 and 11 both take either edge
        default:             edge_o = s3_ff ^ s2_ff;
      endcase
    end
  end
endmodule : iesw_edge_det

// [hdl/iesw_core_end.sv]
// core side model end: drives register access and instruction events
`timescale 1ns/1ps
module iesw_core_end (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // user side requests
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       instr_done_i,
  input  wire logic       brk_i,
  input  wire logic       ei_i,
  output logic [7:0]      rdata_o,
  output logic            iflag_o,
  output logic            brk_flag_o,
  output logic            halted_o,
  output logic [7:0]      vec_addr_o,
  output logic            vec_take_o,
  // link
  iesw_if.core            dev
);
  logic iflag_ff;
  logic brk_flag_ff;
  logic vec_ack_ff;

  // the call is taken one cycle after it is offered, as a vector fetch would
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_ack_ff <= 1'b0;
    end else begin
      vec_ack_ff <= dev.vec_req & ~vec_ack_ff;
    end
  end

  // master enable: cleared on acceptance, set again by enable instruction
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      iflag_ff    <= 1'b0;
      brk_flag_ff <= 1'b0;
    end else begin
      if (ei_i) begin
        iflag_ff <= 1'b1;
      end else if (dev.clr_iflag) begin
        iflag_ff <= 1'b0;
      end
      if (dev.vec_req) begin
        brk_flag_ff <= dev.vec_brk;
      end
    end
  end

  assign dev.reg_wr     = wr_i;
  assign dev.reg_rd     = rd_i;
  assign dev.reg_addr   = addr_i;
  assign dev.reg_wdata  = wdata_i;
  assign dev.psw_iflag  = iflag_ff;
  assign dev.instr_done = instr_done_i & ~dev.cpu_halt;
  assign dev.brk_exec   = brk_i & ~dev.cpu_halt;
  assign dev.iflag_set  = ei_i;
  assign dev.vec_ack    = vec_ack_ff;
  assign rdata_o        = dev.reg_rdata;
  assign iflag_o        = iflag_ff;
  assign brk_flag_o     = brk_flag_ff;
  assign halted_o       = dev.cpu_halt;
  assign vec_addr_o     = dev.vec_addr;
  assign vec_take_o     = dev.vec_req;
endmodule : iesw_core_end

// [tb/iesw_assertions.sv]
// concurrent checks on the link between the controller and the core end
`timescale 1ns/1ps
module iesw_assertions (
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  // link signals
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       psw_iflag,
  input wire logic       instr_done,
  input wire logic       vec_req,
  input wire logic [7:0] vec_addr,
  input wire logic       vec_brk,
  input wire logic       vec_ack,
  input wire logic       push_pc_psw,
  input wire logic       clr_iflag,
  input wire logic       cpu_halt,
  input wire logic       resume
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // acceptance walks clear, push, then the vector call at fixed distances
  chk_accept_chain_seq: assert property (clr_iflag |-> ##2 push_pc_psw ##6 vec_req)
    else $error("acceptance chain out of step");
  chk_accept_needs_ie: assert property (clr_iflag |-> $past(psw_iflag) && $past(instr_done))
    else $error("accepted without master enable or boundary");
  chk_clear_one_pulse: assert property (clr_iflag |=> !clr_iflag)
    else $error("master enable clear not a single pulse");
  chk_vector_held_stable: assert property (vec_req && !vec_ack |=> vec_req && $stable(vec_addr))
    else $error("vector call dropped or changed before ack");
  chk_vector_addr_legal: assert property (vec_req |->
      (vec_addr == iesw_pkg::VEC_BRK) || (vec_addr[7:4] == 4'he && !vec_addr[0]))
    else $error("vector address outside the table");
  chk_break_flag_match: assert property (vec_req |-> vec_brk == (vec_addr == iesw_pkg::VEC_BRK))
    else $error("break flag and vector disagree");
  chk_sleep_halts_cpu: assert property (reg_wr && reg_addr == iesw_pkg::SLEEP_CONTROL_ADDR
      && reg_wdata[iesw_pkg::SLEEP_REQ_BIT] |-> ##[0:4] cpu_halt)
    else $error("sleep write did not halt the core");
  // the wake count alone spans at least 256 clocks, so a shorter halt skipped it
  chk_wake_count_long: assert property ($fell(cpu_halt) |-> $past(cpu_halt, 200))
    else $error("halt released before the wake count ran");
  chk_resume_on_wake: assert property ($fell(cpu_halt) |-> resume == !psw_iflag)
    else $error("resume pulse does not match master enable at wake");
endmodule : iesw_assertions

// [tb/irq_edge_sleep_wake_ctrl_tb.sv]
// self-checking bench joining the controller and the core end
`timescale 1ns/1ps
module irq_edge_sleep_wake_ctrl_tb;
  logic       core_clk_i;
  logic       rst_b_i;
  logic       pa, pb, wr_i, rd_i, idone, brk_i, ei_i;
  logic [5:0] periph;
  logic [7:0] addr_i, wdata_i, rdata_o, vec_addr_o;
  logic       iflag_o, brk_flag_o, halted_o, vec_take_o;
  int         miscompares, n_tests, cyc;

  iesw_if link ();
  iesw_ctrl u_iesw_ctrl (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .port0_bit0_i(pa),
    .port0_bit1_i(pb), .periph_irq_i(periph), .cpu(link));
  iesw_core_end u_iesw_core_end (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .instr_done_i(idone), .brk_i(brk_i),
    .ei_i(ei_i), .rdata_o(rdata_o), .iflag_o(iflag_o), .brk_flag_o(brk_flag_o),
    .halted_o(halted_o), .vec_addr_o(vec_addr_o), .vec_take_o(vec_take_o), .dev(link));
  iesw_assertions u_iesw_assertions (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .psw_iflag(link.psw_iflag), .instr_done(link.instr_done), .vec_req(link.vec_req),
    .vec_addr(link.vec_addr), .vec_brk(link.vec_brk), .vec_ack(link.vec_ack),
    .push_pc_psw(link.push_pc_psw), .clr_iflag(link.clr_iflag), .cpu_halt(link.cpu_halt),
    .resume(link.resume));

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  task give_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data is registered, so it is looked at one half cycle after the taking edge
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk(rdata_o, exp);
  endtask : rd

  task pulse_ei;
    @(posedge core_clk_i);
    ei_i <= 1'b1;
    @(posedge core_clk_i);
    ei_i <= 1'b0;
  endtask : pulse_ei

  task wait_vec(input logic [7:0] exp);
    cyc = 0;
    while (vec_take_o !== 1'b1) begin
      @(negedge core_clk_i);
      cyc++;
      if (cyc > 800) begin
        miscompares++;
        $display("mismatch t=%0t no vector call", $time);
        give_verdict();
      end
    end
    chk(vec_addr_o, exp);
    repeat (2) @(posedge core_clk_i);
  endtask : wait_vec

  task wait_wake;
    cyc = 0;
    while (halted_o !== 1'b0) begin
      @(negedge core_clk_i);
      cyc++;
      if (cyc > 2000) begin
        miscompares++;
        $display("mismatch t=%0t core never woke", $time);
        give_verdict();
      end
    end
  endtask : wait_wake

  // a vector call in this span would be a request that should have been dropped
  task quiet(input int n);
    n_tests++;
    repeat (n) begin
      @(negedge core_clk_i);
      if (vec_take_o !== 1'b0) begin
        miscompares++;
        $display("mismatch t=%0t unexpected vector call", $time);
      end
    end
  endtask : quiet

  initial begin
    miscompares = 0; n_tests = 0; rst_b_i = 1'b0;
    pa = 1'b1; pb = 1'b0; wr_i = 1'b0; rd_i = 1'b0; idone = 1'b1; brk_i = 1'b0;
    ei_i = 1'b0; periph = 6'h00; addr_i = 8'h00; wdata_i = 8'h00;
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 8'he6; a <= 8'heb; a++) rd(8'(a), 8'h00);
    rd(8'hf0, 8'h00);
    wr(iesw_pkg::IRQ_EN_HIGH_ADDR, 8'h40);
    wr(iesw_pkg::EDGE_SELECT_ADDR, 8'h01);
    rd(iesw_pkg::EDGE_SELECT_ADDR, 8'h01);
    pulse_ei();
    pa <= 1'b0;
    quiet(120);
    wr(iesw_pkg::PIN_FUNC_ADDR, 8'h03);
    pa <= 1'b1;
    quiet(120);
    pa <= 1'b0;
    wait_vec(iesw_pkg::VEC_BASE);
    chk(8'(cyc >= iesw_pkg::MIN_RESP_CYCLES * iesw_pkg::MACHINE_DIV), 8'h01);
    chk(8'(iflag_o), 8'h00);
    wr(iesw_pkg::EDGE_SELECT_ADDR, 8'h09);
    wr(iesw_pkg::IRQ_EN_HIGH_ADDR, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      pulse_ei();
      pb <= ~pb;
      wait_vec(8'he2);
    end
    // second line back to rising only: a rise calls, a fall does not
    wr(iesw_pkg::EDGE_SELECT_ADDR, 8'h01);
    pulse_ei();
    pb <= 1'b1;
    wait_vec(8'he2);
    pulse_ei();
    pb <= 1'b0;
    quiet(120);
    // two peripheral levels together, then a break held behind them
    wr(iesw_pkg::IRQ_EN_LOW_ADDR, 8'h03);
    periph <= 6'h03;
    pulse_ei();
    wait_vec(8'he4);
    periph <= 6'h02;
    pulse_ei();
    wait_vec(8'he6);
    periph <= 6'h01;
    @(posedge core_clk_i);
    brk_i <= 1'b1;
    @(posedge core_clk_i);
    brk_i <= 1'b0;
    pulse_ei();
    wait_vec(8'he4);
    chk(8'(brk_flag_o), 8'h00);
    periph <= 6'h00;
    pulse_ei();
    wait_vec(iesw_pkg::VEC_BRK);
    chk(8'(brk_flag_o), 8'h01);
    wr(iesw_pkg::IRQ_EN_HIGH_ADDR, 8'h40);
    pulse_ei();
    pb <= ~pb;
    quiet(120);
    // sleep with the master enable set: wake vectors
    wr(iesw_pkg::IRQ_EN_LOW_ADDR, 8'h01);
    // prescale kept tiny so the run stays short; real software needs far more
    wr(iesw_pkg::BIT_PRESCALE_ADDR, 8'h01);
    wr(iesw_pkg::SLEEP_CONTROL_ADDR, 8'h01);
    repeat (20) @(posedge core_clk_i);
    chk(8'(halted_o), 8'h01);
    periph <= 6'h01;
    wait_wake();
    chk(8'(cyc >= (int'(iesw_pkg::BIT_TOP) + 1) * 2 - 1), 8'h01);
    wait_vec(8'he4);
    periph <= 6'h00;
    // sleep with the master enable clear: wake resumes without a call
    wr(iesw_pkg::SLEEP_CONTROL_ADDR, 8'h01);
    repeat (20) @(posedge core_clk_i);
    periph <= 6'h01;
    wait_wake();
    quiet(80);
    periph <= 6'h00;
    rd(iesw_pkg::SLEEP_CONTROL_ADDR, 8'h00);
    rd(iesw_pkg::EDGE_SELECT_ADDR, 8'h01);
    rd(iesw_pkg::BIT_PRESCALE_ADDR, 8'h01);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(iesw_pkg::EDGE_SELECT_ADDR, iesw_pkg::EDGE_SELECT_RST);
    rd(iesw_pkg::BIT_PRESCALE_ADDR, iesw_pkg::BIT_PRESCALE_RST);
    give_verdict();
  end
endmodule : irq_edge_sleep_wake_ctrl_tb
